// File: core/til_learn.sv
// transmitter identity learning, clearing and filtering core
`timescale 1ns/1ns
`default_nettype none
module til_learn #(
    parameter int unsigned IND_CYCLES = til_pkg::IND_CYCLES
)(
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    // mode pins: open reads high, grounded reads low
    input  wire logic              i_mode_select_a,
    output logic                   o_mode_select_a,
    output logic                   o_mode_select_a_oe_n,
    input  wire logic              i_mode_select_b,
    output logic                   o_mode_select_b,
    output logic                   o_mode_select_b_oe_n,
    input  wire logic              i_learn_select,
    // decoded message from the radio, same clock domain
    input  wire logic              i_msg_valid,
    input  wire til_pkg::til_msg_t i_msg,
    // nonvolatile store image: loaded at power-up, written back on change
    input  wire til_pkg::til_slot_t i_nv_image [til_pkg::STORE_DEPTH],
    output til_pkg::til_slot_t     o_nv_image [til_pkg::STORE_DEPTH],
    output logic                   o_nv_write,
    // switch data forwarded to the output stage
    output logic [til_pkg::SW_W-1:0] o_sw_data,
    output logic                   o_sw_valid,
    output til_pkg::til_mode_t     o_mode
);
    localparam int unsigned DEPTH = til_pkg::STORE_DEPTH;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] pins_meta_q;
    logic [2:0] pins_sync_q;

    // first stage read only by the second
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pins_meta_q <= 3'h7;
            pins_sync_q <= 3'h7;
        end
        else
        begin
            pins_meta_q <= {i_mode_select_a, i_mode_select_b, i_learn_select};
            pins_sync_q <= pins_meta_q;
        end
    end

    // ------------------------------------------------------------
    // power-up load: wait for synchronisers, then latch mode once
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_WAIT = 2'b00,
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } til_state_t;

    til_state_t         state_q;
    til_state_t         state_d;
    logic [2:0]         wait_q;
    til_pkg::til_mode_t mode_q;
    til_pkg::til_mode_t strap_mode;

    // strap decode; unlisted combinations (clear-all, output modes) run normal
    assign strap_mode =
        (pins_sync_q == 3'b110) ? til_pkg::TIL_MODE_REGISTER :
        (pins_sync_q == 3'b010) ? til_pkg::TIL_MODE_CLEAR    :
                                  til_pkg::TIL_MODE_NORMAL;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_WAIT: if (wait_q == 3'(til_pkg::STRAP_WAIT)) state_d = ST_LOAD;
            ST_LOAD: state_d = ST_RUN;
            ST_RUN:  state_d = ST_RUN;
            default: state_d = ST_WAIT;
        endcase
    end

    // mode is captured once, so pin changes later have no effect
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_q <= ST_WAIT;
            wait_q  <= 3'h0;
            mode_q  <= til_pkg::TIL_MODE_IDLE;
        end
        else
        begin
            state_q <= state_d;
            if (state_q == ST_WAIT)
                wait_q <= wait_q + 3'h1;
            if (state_q == ST_LOAD)
                mode_q <= strap_mode;
        end
    end

    // ------------------------------------------------------------
    // identity store and match
    // ------------------------------------------------------------
    til_pkg::til_slot_t store_q [DEPTH];
    logic [DEPTH-1:0]   hit;
    logic               any_hit;
    logic [til_pkg::IDX_W-1:0] hit_idx;
    logic               run_msg;
    logic               do_reg;
    logic               do_clr;

    // match vector shared by registration, filtering and clearing
    always_comb
    begin
        hit_idx = '0;
        for (int i = 0; i < DEPTH; i++)
        begin
            hit[i] = store_q[i].valid && (store_q[i].id == i_msg.id);
        end
        for (int i = DEPTH - 1; i >= 0; i--)
        begin
            if (hit[i]) hit_idx = til_pkg::IDX_W'(i);
        end
    end

    assign any_hit = |hit;
    assign run_msg = (state_q == ST_RUN) && i_msg_valid;
    assign do_reg  = run_msg && (mode_q == til_pkg::TIL_MODE_REGISTER);
    assign do_clr  = run_msg && (mode_q == til_pkg::TIL_MODE_CLEAR) && any_hit;

    // registration shifts in at entry 0 and drops the last; a known id moves to the
    // front without duplicating. clearing closes the gap above the removed entry
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            for (int i = 0; i < DEPTH; i++) store_q[i] <= '0;
        end
        else if (state_q == ST_LOAD)
        begin
            for (int i = 0; i < DEPTH; i++) store_q[i] <= i_nv_image[i];
        end
        else if (do_reg)
        begin
            store_q[0] <= '{id: i_msg.id, valid: 1'b1};
            for (int i = 1; i < DEPTH; i++)
            begin
                if (!any_hit || i <= int'(hit_idx))
                    store_q[i] <= store_q[i-1];
            end
        end
        else if (do_clr)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
            begin
                if (i >= int'(hit_idx))
                    store_q[i] <= store_q[i+1];
            end
            store_q[DEPTH-1] <= '0;   // top slot always frees up; never reads past the end
        end
    end

    // nonvolatile write-back image; no read port exists beyond this mirror
    always_comb
    begin
        for (int i = 0; i < DEPTH; i++) o_nv_image[i] = store_q[i];
    end

    // ------------------------------------------------------------
    // forwarding and indication timing
    // ------------------------------------------------------------
    logic [31:0] ind_cnt_q;
    logic        ind_a_q;
    logic        ind_b_q;
    logic        nv_write_q;
    logic [til_pkg::SW_W-1:0] sw_q;
    logic        sw_valid_q;

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            ind_cnt_q  <= 32'h0;
            ind_a_q    <= 1'b0;
            ind_b_q    <= 1'b0;
            nv_write_q <= 1'b0;
            sw_q       <= '0;
            sw_valid_q <= 1'b0;
        end
        else
        begin
            nv_write_q <= do_reg || do_clr;
            sw_valid_q <= run_msg && (mode_q == til_pkg::TIL_MODE_NORMAL) && any_hit;
            if (run_msg && (mode_q == til_pkg::TIL_MODE_NORMAL) && any_hit)
                sw_q <= i_msg.sw;
            if (do_reg || do_clr)
            begin
                ind_cnt_q <= IND_CYCLES;
                ind_a_q   <= do_reg;
                ind_b_q   <= do_clr;
            end
            else if (ind_cnt_q != 32'h0)
            begin
                ind_cnt_q <= ind_cnt_q - 32'h1;
                if (ind_cnt_q == 32'h1)
                begin
                    ind_a_q <= 1'b0;
                    ind_b_q <= 1'b0;
                end
            end
        end
    end

    // pins stay released while loading; afterwards driven low only when indicating
    assign o_mode_select_a      = 1'b0;
    assign o_mode_select_b      = 1'b0;
    assign o_mode_select_a_oe_n = !(ind_a_q && state_q == ST_RUN);
    assign o_mode_select_b_oe_n = !(ind_b_q && state_q == ST_RUN);
    assign o_nv_write           = nv_write_q;
    assign o_sw_data            = sw_q;
    assign o_sw_valid           = sw_valid_q;
    assign o_mode               = mode_q;

endmodule // til_learn
`default_nettype wire

// File: core/til_pkg.sv
// package: constants, modes and message carrier for transmitter identity learning
`default_nettype none
package til_pkg;

    // ------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------
    localparam int unsigned ID_W          = 24;
    localparam int unsigned SW_W          = 6;
    localparam int unsigned STORE_DEPTH   = 100;
    localparam int unsigned IDX_W         = 7;
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned IND_TIME_MS   = 2000;
    localparam int unsigned IND_CYCLES    = (CLK_HZ / 1000) * IND_TIME_MS;
    localparam int unsigned STRAP_WAIT    = 4;

    // ------------------------------------------------------------
    // operating modes chosen at power-up, plus idle until the straps are latched
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        TIL_MODE_NORMAL   = 2'b00,
        TIL_MODE_REGISTER = 2'b01,
        TIL_MODE_CLEAR    = 2'b10,
        TIL_MODE_IDLE     = 2'b11
    } til_mode_t;

    // received message: identity plus switch data
    typedef struct packed
    {
        logic [ID_W-1:0] id;
        logic [SW_W-1:0] sw;
    } til_msg_t;

    // image exchanged with the nonvolatile backing store
    typedef struct packed
    {
        logic [ID_W-1:0] id;
        logic            valid;
    } til_slot_t;

endpackage
`default_nettype wire

// File: verification/til_learn_asserts.sv
// port assertions for the identity learning core
`timescale 1ns/1ns
`default_nettype none
module til_learn_asserts #(
    parameter int unsigned IND_CYCLES = 20
)(
    input wire logic               i_clk,
    input wire logic               i_resetn,
    input wire logic               i_msg_valid,
    input wire logic               o_mode_select_a_oe_n,
    input wire logic               o_mode_select_b_oe_n,
    input wire logic               o_nv_write,
    input wire logic               o_sw_valid,
    input wire til_pkg::til_mode_t o_mode
);
    // ----------
    // low time of the a indication, restarted by each store change
    // ----------
    logic [31:0] low_q;
    always_ff @(posedge i_clk or negedge i_resetn)
        if (!i_resetn)
            low_q <= 32'h0;
        else
            low_q <= o_mode_select_a_oe_n ? 32'h0 : (o_nv_write ? 32'h1 : low_q + 32'h1);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    AST_REG_ACK: assert property (i_msg_valid && o_mode == til_pkg::TIL_MODE_REGISTER
        |=> !o_mode_select_a_oe_n && o_nv_write) else $error("no registration ack");
    AST_A_CAUSE: assert property ($fell(o_mode_select_a_oe_n)
        |-> o_mode == til_pkg::TIL_MODE_REGISTER && $past(i_msg_valid)) else $error("a low");
    AST_B_CAUSE: assert property ($fell(o_mode_select_b_oe_n)
        |-> o_mode == til_pkg::TIL_MODE_CLEAR && $past(i_msg_valid)) else $error("b low");
    AST_A_HOLD: assert property ($fell(o_mode_select_a_oe_n)
        |-> !o_mode_select_a_oe_n [*8]) else $error("a released early");
    AST_A_LEN: assert property ($rose(o_mode_select_a_oe_n)
        |-> low_q == IND_CYCLES) else $error("a low length");
    AST_FWD: assert property (o_sw_valid
        |-> o_mode == til_pkg::TIL_MODE_NORMAL && $past(i_msg_valid)) else $error("fwd");
    AST_IDLE: assert property (o_mode == til_pkg::TIL_MODE_IDLE
        |-> o_mode_select_a_oe_n && o_mode_select_b_oe_n && !o_sw_valid) else $error("idle");
    AST_MODE_KEPT: assert property (o_mode != til_pkg::TIL_MODE_IDLE
        |=> $stable(o_mode)) else $error("mode changed");
    AST_NV_CAUSE: assert property (o_nv_write
        |-> $past(i_msg_valid) && o_mode != til_pkg::TIL_MODE_NORMAL) else $error("nv");
endmodule // til_learn_asserts
`default_nettype wire

// File: verification/til_partner.sv
// far side model: transmitter messages and the nonvolatile store
`timescale 1ns/1ns
`default_nettype none
module til_partner (
    input wire logic                i_clk,
    input wire til_pkg::til_slot_t  i_image [til_pkg::STORE_DEPTH],
    input wire logic                i_write,
    output til_pkg::til_slot_t      o_image [til_pkg::STORE_DEPTH],
    output logic                    o_valid,
    output til_pkg::til_msg_t       o_msg
);
    // store survives every reset of the core, only a write changes it
    initial
    begin
        foreach (o_image[k]) o_image[k] = '0;
        o_valid = 1'b0;
        o_msg = '0;
    end
    always @(posedge i_clk) if (i_write) o_image <= i_image;
    // one message per cycle, changed off the sampling edge
    task automatic send(input logic [23:0] id, input logic [5:0] sw);
        @(negedge i_clk);
        o_valid = 1'b1;
        o_msg = {id, sw};
    endtask
    // idle line: scrambled so stale data never looks valid
    task automatic quiet();
        @(negedge i_clk);
        o_valid = 1'b0;
        o_msg = ~o_msg;
    endtask
endmodule // til_partner
`default_nettype wire

// File: verification/til_learn_test.sv
// self-checking testbench for the identity learning core
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
    $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module til_learn_test;
    localparam int IC = 20;
    logic clk = 1'b0, rstn = 1'b0, sa = 1'b1, sb = 1'b1, sl = 1'b1;
    logic oa, oea, ob, oeb, nvw, swv;
    logic [5:0] swd;
    til_pkg::til_mode_t mode;
    til_pkg::til_slot_t nv_in [til_pkg::STORE_DEPTH];
    til_pkg::til_slot_t nv_out [til_pkg::STORE_DEPTH];
    til_pkg::til_msg_t msg;
    logic vld;
    int errors = 0, total_checks = 0;
    // pin level: strap unless the core pulls it
    wire pa = oea ? sa : oa;
    wire pb = oeb ? sb : ob;
    til_learn #(.IND_CYCLES(IC)) til_learn_i (.i_clk(clk), .i_resetn(rstn),
        .i_mode_select_a(pa), .o_mode_select_a(oa), .o_mode_select_a_oe_n(oea),
        .i_mode_select_b(pb), .o_mode_select_b(ob), .o_mode_select_b_oe_n(oeb),
        .i_learn_select(sl), .i_msg_valid(vld), .i_msg(msg), .i_nv_image(nv_in),
        .o_nv_image(nv_out), .o_nv_write(nvw), .o_sw_data(swd), .o_sw_valid(swv),
        .o_mode(mode));
    til_partner til_partner_i (.i_clk(clk), .i_image(nv_out), .i_write(nvw),
        .o_image(nv_in), .o_valid(vld), .o_msg(msg));
    initial forever #20 clk = ~clk;
    initial
    begin
        #200000;
        errors++;
        final_report();
    end
    task automatic final_report();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // power cycle with straps set while off; mode pins read once
    task automatic power(input logic a, input logic b, input logic l);
        @(negedge clk);
        rstn = 1'b0; sa = a; sb = b; sl = l;
        repeat (2) @(negedge clk);
        `CHK(oea & oeb, 1'b1)
        rstn = 1'b1;
        repeat (9) @(negedge clk);
    endtask
    task automatic msg1(input logic [23:0] id, input logic [5:0] sw);
        til_partner_i.send(id, sw);
        til_partner_i.quiet();
    endtask
    task automatic t_reg();
        int n;
        msg1(24'hA5A5A5, 6'h01);
        `CHK(oea, 1'b0)
        `CHK(nvw, 1'b1)
        `CHK(nv_out[0].id, 24'hA5A5A5)
        n = 1;
        while (oea === 1'b0 && n < 200) begin @(negedge clk); n++; end
        `CHK(n, IC + 1)
        msg1(24'h00BEEF, 6'h02);
        `CHK(oea, 1'b0)
        `CHK(nv_out[1].id, 24'hA5A5A5)
        `CHK(pa, 1'b0)
        // a known identity moves to the front and is not stored twice
        msg1(24'hA5A5A5, 6'h03);
        `CHK(nv_out[0].id, 24'hA5A5A5)
        `CHK(nv_out[1].id, 24'h00BEEF)
        `CHK(nv_out[2].valid, 1'b0)
    endtask
    // back-to-back burst of 100 fills the whole store and pushes out both old entries
    task automatic t_fill();
        for (int i = 1; i <= 100; i++) til_partner_i.send(24'(i), 6'h04);
        til_partner_i.quiet();
        `CHK(nv_out[0].id, 24'h000064)
        `CHK(nv_out[99].id, 24'h000001)
        repeat (3) @(negedge clk);
    endtask
    task automatic t_norm();
        msg1(24'h000032, 6'h2A);
        `CHK({swv, swd}, 7'h6A)
        msg1(24'hA5A5A5, 6'h15);
        `CHK(swv, 1'b0)
        `CHK(oea, 1'b1)
    endtask
    task automatic t_clear();
        msg1(24'h000032, 6'h08);
        `CHK({oea, oeb}, 2'h2)
        `CHK(pb, 1'b0)
        `CHK(nv_out[50].id, 24'h000031)
        `CHK(nv_out[49].id, 24'h000033)
        `CHK(nv_out[99].valid, 1'b0)
        msg1(24'hFFFFFF, 6'h08);
        `CHK(nvw, 1'b0)
        // no indication: the operator starts over from power-off and retries
        power(1'b0, 1'b1, 1'b0);
        msg1(24'h000033, 6'h08);
        `CHK({oea, oeb}, 2'h2)
        `CHK(nv_out[49].id, 24'h000031)
        repeat (3) @(negedge clk);
        power(1'b1, 1'b1, 1'b1);
        msg1(24'h000032, 6'h10);
        `CHK(swv, 1'b0)
        msg1(24'h000031, 6'h10);
        `CHK(swv, 1'b1)
    endtask
    initial
    begin
        power(1'b1, 1'b1, 1'b0);
        `CHK(mode, til_pkg::TIL_MODE_REGISTER)
        t_reg();
        t_fill();
        power(1'b1, 1'b1, 1'b1);
        `CHK(mode, til_pkg::TIL_MODE_NORMAL)
        t_norm();
        power(1'b0, 1'b1, 1'b0);
        `CHK(mode, til_pkg::TIL_MODE_CLEAR)
        t_clear();
        final_report();
    end
endmodule // til_learn_test
bind til_learn til_learn_asserts #(.IND_CYCLES(IND_CYCLES)) til_learn_asserts_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_msg_valid(i_msg_valid),
    .o_mode_select_a_oe_n(o_mode_select_a_oe_n), .o_mode_select_b_oe_n(o_mode_select_b_oe_n),
    .o_nv_write(o_nv_write), .o_sw_valid(o_sw_valid), .o_mode(o_mode));
`default_nettype wire
